//--- core/pilot_ignition_retry_sequencer.sv
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`include "ign_params.svh"
module pilot_ignition_retry_sequencer #(
  parameter logic [16:0] TICK_CYC    = 17'(`TICK_NS / `CLK_NS),
  parameter logic [18:0] TRIAL_SHORT = 19'(`TRIAL_SHORT_MS),
  parameter logic [18:0] TRIAL_LONG  = 19'(`TRIAL_LONG_MS),
  parameter logic [18:0] PURGE_LEN   = 19'(`PURGE_MS),
  parameter logic [18:0] WAIT_LEN    = 19'(`WAIT_MS)
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // appliance pins
  input  wire logic        heat_req_i,
  input  wire logic        flame_i,
  input  wire logic        damper_conn_i,
  output logic             spark_o,
  output logic             pilot_valve_o,
  output logic             main_valve_o,
  output logic             damper_pwr_o,
  output logic             led_o,
  output logic             irq_o
);
  ign_pkg::seq_q_t    q;
  ign_pkg::seq_q_t    n;
  logic [2:0]         pins_s;
  logic               heat_s;
  logic               flame_s;
  logic               damp_s;
  logic               permit;
  logic               req;
  logic [18:0]        trial_lim;
  logic [3:0]         ev;
  logic [3:0]         clr;
  logic [31:0]        rd;
  ign_pkg::led_mode_t led_mode;
  logic [2:0]         led_code;

  // pins come from the appliance wiring, so they are synchronised first
  sync2 #(
    .W (3)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({heat_req_i, flame_i, damper_conn_i}),
    .q_o   (pins_s)
  );

  assign heat_s  = pins_s[2];
  assign flame_s = pins_s[1];
  assign damp_s  = pins_s[0];

  // a latched damper must be present, otherwise the sequence may not run
  assign permit    = heat_s && (!q.damp_seen || damp_s);
  assign trial_lim = q.ctrl[`CTRL_LONG_BIT] ? TRIAL_LONG : TRIAL_SHORT;
  assign req       = wb_cyc_i && wb_stb_i && !q.ack;

  // status word: state, flame, heat, damper latch, damper, retry count
  function automatic logic [31:0] stat_word(ign_pkg::seq_q_t s, logic h, logic f, logic d);
    stat_word = {16'h0000, s.retries, 1'b0, d, s.damp_seen, h, f, s.st};
  endfunction

  // sequencer, timebase and register file in one next-state process
  always_comb begin
    n      = q;
    ev     = '0;
    clr    = '0;
    rd     = '0;

    // 1 ms tick; all sequence timing counts ticks so counters stay small
    n.tick = 1'b0;
    if (q.pre == 17'(TICK_CYC - 17'h00001)) begin
      n.pre  = '0;
      n.tick = 1'b1;
    end else begin
      n.pre = 17'(q.pre + 17'h00001);
    end
    if (q.tick && (q.ms != '1)) begin
      n.ms = 19'(q.ms + 19'h00001);
    end

    unique case (q.st)
      ign_pkg::S_IDLE: begin
        if (permit) begin
          n.st = q.ctrl[`CTRL_PURGE_BIT] ? ign_pkg::S_PURGE : ign_pkg::S_TRIAL;
        end
      end
      ign_pkg::S_PURGE: begin
        if (q.ms >= PURGE_LEN) begin
          n.st = ign_pkg::S_TRIAL;
        end
      end
      ign_pkg::S_TRIAL: begin
        // flame wins over an expiring timer in the same cycle
        if (flame_s) begin
          n.st           = ign_pkg::S_RUN;
          ev[`IRQ_PROVEN] = 1'b1;
        end else if (q.ms >= trial_lim) begin
          n.st               = ign_pkg::S_WAIT;
          ev[`IRQ_TRIAL_FAIL] = 1'b1;
          if (q.retries != '1) begin
            n.retries = 8'(q.retries + 8'h01);
          end
        end
      end
      ign_pkg::S_RUN: begin
        // relight at once; no wait after a flame that did prove once
        if (!flame_s) begin
          n.st               = ign_pkg::S_TRIAL;
          ev[`IRQ_FLAME_LOST] = 1'b1;
        end
      end
      ign_pkg::S_WAIT: begin
        // no lockout: the wait always leads to a new sequence
        if (q.ms >= WAIT_LEN) begin
          n.st = q.ctrl[`CTRL_PURGE_BIT] ? ign_pkg::S_PURGE : ign_pkg::S_TRIAL;
        end
      end
    endcase

    // loss of heat request or latched damper overrides everything
    if (!permit) begin
      n.st = ign_pkg::S_IDLE;
    end
    if (!heat_s) begin
      n.retries = '0;
    end
    if (n.st != q.st) begin
      n.ms = '0;
    end

    // damper is powered with the heat request; seeing it once latches
    n.damp_pwr = heat_s;
    if (q.damp_pwr && damp_s) begin
      n.damp_seen = 1'b1;
    end
    ev[`IRQ_DAMPER] = heat_s && q.damp_seen && !damp_s && (q.st != ign_pkg::S_IDLE);

    // outputs decode the next state so they line up with the state register
    n.spark  = (n.st == ign_pkg::S_TRIAL);
    n.pilot  = (n.st == ign_pkg::S_TRIAL) || (n.st == ign_pkg::S_RUN);
    n.main_v = (n.st == ign_pkg::S_RUN);

    // register access, answered one cycle after the request
    n.ack = req;
    if (req) begin
      unique case (wb_adr_i)
        `ADR_CTRL: begin
          rd = {30'h0, q.ctrl};
          if (wb_we_i && wb_sel_i[0]) begin
            n.ctrl = wb_dat_i[1:0];
          end
        end
        `ADR_STAT: rd = stat_word(q, heat_s, flame_s, damp_s);
        `ADR_IRQ: begin
          rd = {28'h0000000, q.irq};
          if (!wb_we_i) begin
            clr = '1;
          end
        end
        `ADR_MASK: begin
          rd = {28'h0000000, q.mask};
          if (wb_we_i && wb_sel_i[0]) begin
            n.mask = wb_dat_i[3:0];
          end
        end
        default: rd = '0;
      endcase
    end
    n.rdat = (req && !wb_we_i) ? rd : 32'h00000000;

    // read clears, but an event in the same cycle stays set
    n.irq = (q.irq & ~clr) | ev;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q      <= '0;
      q.st   <= ign_pkg::S_IDLE;
      q.ctrl <= `CTRL_RST;
    end else begin
      q <= n;
    end
  end

  // led: error codes take priority, then flame, then activity
  always_comb begin
    led_code = `CODE_WAIT;
    if (heat_s && q.damp_seen && !damp_s) begin
      led_mode = ign_pkg::LED_CODE;
      led_code = `CODE_DAMPER;
    end else if (q.st == ign_pkg::S_WAIT) begin
      led_mode = ign_pkg::LED_CODE;
    end else if (flame_s || (q.st == ign_pkg::S_RUN)) begin
      led_mode = ign_pkg::LED_ON;
    end else if (q.st != ign_pkg::S_IDLE) begin
      led_mode = ign_pkg::LED_SLOW;
    end else begin
      led_mode = ign_pkg::LED_OFF;
    end
  end

  led_pattern u_led (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (q.tick),
    .mode_i (led_mode),
    .code_i (led_code),
    .led_o  (led_o)
  );

  // outputs straight from the state register
  assign spark_o       = q.spark;
  assign pilot_valve_o = q.pilot;
  assign main_valve_o  = q.main_v;
  assign damper_pwr_o  = q.damp_pwr;
  assign wb_ack_o      = q.ack;
  assign wb_dat_o      = q.rdat;
  assign irq_o         = |(q.irq & q.mask);

  // checks on the sequence
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  spark_pilot_a: assert property (spark_o |-> pilot_valve_o && !main_valve_o)
    else $error("spark without pilot or with main open");

  trial_len_a: assert property ((q.st == ign_pkg::S_TRIAL) |-> (q.ms <= trial_lim))
    else $error("trial ran past its limit");

  trial_sel_a: assert property ((q.st == ign_pkg::S_TRIAL) && !flame_s && permit && q.ms == trial_lim
      |=> (q.st == ign_pkg::S_WAIT) && q.ms == 19'h00000)
    else $error("trial did not end at the selected length");

  fail_shutoff_a: assert property ((q.st == ign_pkg::S_TRIAL) ##1 (q.st == ign_pkg::S_WAIT)
      |-> !spark_o && !pilot_valve_o && !main_valve_o)
    else $error("gas left on after failed trial");

  wait_quiet_a: assert property ((q.st == ign_pkg::S_WAIT) |-> !spark_o && !pilot_valve_o && !main_valve_o)
    else $error("output active during retry wait");

  retry_wait_a: assert property ((q.st == ign_pkg::S_WAIT) && q.ms >= WAIT_LEN && permit
      |=> (q.st inside {ign_pkg::S_PURGE, ign_pkg::S_TRIAL}))
    else $error("no new trial after the wait");

  main_proven_a: assert property ($rose(main_valve_o) |-> $past(flame_s) && $past(pilot_valve_o))
    else $error("main valve opened without proven flame");

  purge_quiet_a: assert property ((q.st == ign_pkg::S_PURGE) |-> !spark_o && !pilot_valve_o && !main_valve_o)
    else $error("output active during prepurge");

  flame_loss_a: assert property ((q.st == ign_pkg::S_RUN) && !flame_s |=> !main_valve_o)
    else $error("main valve stayed open after flame loss");

  relight_a: assert property ((q.st == ign_pkg::S_RUN) && !flame_s && permit
      |=> (q.st == ign_pkg::S_TRIAL) && spark_o)
    else $error("no immediate relight after flame loss");

  heat_drop_a: assert property (!heat_s |=> (q.st == ign_pkg::S_IDLE) && !spark_o && !pilot_valve_o
      && !main_valve_o)
    else $error("outputs active without heat request");

  damper_lock_a: assert property (q.damp_seen && !damp_s |=> !pilot_valve_o && !main_valve_o)
    else $error("sequence ran with latched damper missing");

  led_flame_a: assert property ((q.st == ign_pkg::S_RUN) [*3] |-> led_o)
    else $error("led dark while flame sensed");

  // stage timing and latches; a stuck timer would hide a missed limit
  purge_len_a: assert property ((q.st == ign_pkg::S_PURGE)
      |-> (q.ms <= PURGE_LEN))
    else $error("prepurge ran past its length");

  wait_len_a: assert property ((q.st == ign_pkg::S_WAIT)
      |-> (q.ms <= WAIT_LEN))
    else $error("retry wait ran past its length");

  retry_count_a: assert property ((q.st == ign_pkg::S_TRIAL) ##1 (q.st == ign_pkg::S_WAIT)
      |-> (q.retries != 8'h00))
    else $error("failed trial not counted");

  run_flame_a: assert property ((q.st == ign_pkg::S_RUN)
      |-> $past(flame_s))
    else $error("run state held without flame");

  idle_quiet_a: assert property ((q.st == ign_pkg::S_IDLE)
      |-> !spark_o && !pilot_valve_o && !main_valve_o)
    else $error("output active while idle");

  damper_latch_a: assert property (q.damp_seen
      |=> q.damp_seen)
    else $error("damper latch cleared");

  damper_pwr_a: assert property ((damper_pwr_o
      == $past(heat_s)))
    else $error("damper power does not follow the heat request");

  state_timer_a: assert property ((q.st != $past(q.st))
      |-> (q.ms == 19'h00000))
    else $error("stage timer not restarted on a state change");

  tick_gap_a: assert property (q.tick
      |=> !q.tick)
    else $error("timebase tick longer than one cycle");

  // register bus and status bookkeeping
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o)
    else $error("register request not answered in one cycle");

  ack_pulse_a: assert property (wb_ack_o
      |=> !wb_ack_o)
    else $error("acknowledge held for more than one cycle");

  rdat_idle_a: assert property (!wb_ack_o
      |-> (wb_dat_o == 32'h00000000))
    else $error("read data not zero outside an acknowledge");

  irq_hold_a: assert property (!(req && !wb_we_i && (wb_adr_i == `ADR_IRQ))
      |=> (($past(q.irq) & ~q.irq) == 4'h0))
    else $error("status bit dropped without a status read");

  fail_event_a: assert property ((q.st == ign_pkg::S_TRIAL) ##1 (q.st == ign_pkg::S_WAIT)
      |-> q.irq[`IRQ_TRIAL_FAIL])
    else $error("failed trial left no status bit");

  proven_event_a: assert property ($rose(main_valve_o)
      |-> q.irq[`IRQ_PROVEN])
    else $error("proven flame left no status bit");

  lightoff_c:   cover property ((q.st == ign_pkg::S_TRIAL) ##1 (q.st == ign_pkg::S_RUN));
  trial_fail_c: cover property ((q.st == ign_pkg::S_TRIAL) ##1 (q.st == ign_pkg::S_WAIT));
  relight_c:    cover property ((q.st == ign_pkg::S_RUN) ##1 (q.st == ign_pkg::S_TRIAL));
  damper_c:     cover property (q.damp_seen && !damp_s && heat_s);
  wait_retry_c: cover property ((q.st == ign_pkg::S_WAIT) ##1 (q.st == ign_pkg::S_TRIAL));
endmodule

//--- core/ign_params.svh
`ifndef IGN_PARAMS_SVH
`define IGN_PARAMS_SVH
// Notes on behaviour
// - pilot trial lasts at most 90 seconds
// - failed trial: all off, five-minute wait, retry
// - retry forever, no lockout state
// - main valve only after proven pilot flame
// - failed trial shuts spark, pilot and main
// - spark and pilot together until flame/timeout
// - prepurge zero or 30 s, outputs off
// - trial length selectable 15 or 90 s
// - flame loss closes gas within 2 s
// - damper once powered must stay connected
// - green led shows state, codes, flame

// timebase
`define CLK_NS           10
`define TICK_NS          1000000
`define TRIAL_SHORT_MS   15000
`define TRIAL_LONG_MS    90000
`define PURGE_MS         30000
`define WAIT_MS          300000
`define LED_HALF_MS      250
`define LED_GAP_HALVES   4

// register byte offsets
`define ADR_CTRL         8'h00
`define ADR_STAT         8'h04
`define ADR_IRQ          8'h08
`define ADR_MASK         8'h0c

// control fields and reset value
`define CTRL_PURGE_BIT   0
`define CTRL_LONG_BIT    1
`define CTRL_RST         2'h2

// interrupt status bits
`define IRQ_TRIAL_FAIL   0
`define IRQ_FLAME_LOST   1
`define IRQ_PROVEN       2
`define IRQ_DAMPER       3

// led error codes (flash counts)
`define CODE_WAIT        3'h2
`define CODE_DAMPER      3'h3
`endif

//--- core/ign_pkg.sv
package ign_pkg;
  typedef enum logic [2:0] {S_IDLE, S_PURGE, S_TRIAL, S_RUN, S_WAIT} seq_st_t;
  typedef enum logic [1:0] {LED_OFF, LED_ON, LED_SLOW, LED_CODE} led_mode_t;

  // whole state of the sequencer
  typedef struct packed {
    seq_st_t     st;
    logic [18:0] ms;
    logic [16:0] pre;
    logic        tick;
    logic [1:0]  ctrl;
    logic [3:0]  irq;
    logic [3:0]  mask;
    logic [7:0]  retries;
    logic        damp_seen;
    logic        spark;
    logic        pilot;
    logic        main_v;
    logic        damp_pwr;
    logic        ack;
    logic [31:0] rdat;
  } seq_q_t;

  typedef struct packed {
    logic [9:0] ms;
    logic [4:0] slot;
    logic       led;
  } led_q_t;
endpackage

//--- core/sync2.sv
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 3
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_q_t;

  sync_q_t q;
  sync_q_t n;

  // first stage feeds only the second stage
  always_comb begin
    n    = q;
    n.s1 = d_i;
    n.s2 = q.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign q_o = q.s2;
endmodule

//--- core/led_pattern.sv
`timescale 1ns/1ps
`include "ign_params.svh"
module led_pattern (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               tick_i,
  input  wire ign_pkg::led_mode_t mode_i,
  input  wire logic [2:0]         code_i,
  output logic                    led_o
);
  ign_pkg::led_q_t q;
  ign_pkg::led_q_t n;
  logic [4:0]      flashes;
  logic [4:0]      last;

  // slots are half periods; a code is n flashes then a dark gap
  always_comb begin
    n       = q;
    flashes = {1'b0, code_i, 1'b0};
    last    = 5'(flashes + 5'(`LED_GAP_HALVES) - 5'h01);
    if (tick_i) begin
      if (q.ms == 10'(`LED_HALF_MS - 1)) begin
        n.ms   = '0;
        n.slot = (q.slot >= last) ? 5'h00 : 5'(q.slot + 5'h01);
      end else begin
        n.ms = 10'(q.ms + 10'h001);
      end
    end
    unique case (mode_i)
      ign_pkg::LED_OFF:  n.led = 1'b0;
      ign_pkg::LED_ON:   n.led = 1'b1;
      ign_pkg::LED_SLOW: n.led = q.slot[0];
      ign_pkg::LED_CODE: n.led = (q.slot < flashes) && !q.slot[0];
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign led_o = q.led;
endmodule

//--- verif/appliance_model.sv
`timescale 1ns/1ps
// behavioural burner: pilot lights after some sparking, goes dark without gas
module appliance_model (
  input  wire logic       clk_i,
  input  wire logic       spark_i,
  input  wire logic       pilot_i,
  input  wire logic       light_en_i,
  input  wire logic [3:0] dly_i,
  output logic            flame_o
);
  int unsigned cnt = 0;

  initial flame_o = 1'b0;

  // light_en low models a pilot that will not catch or is blown out
  always @(posedge clk_i) begin
    if (!pilot_i || !light_en_i) begin
      flame_o <= 1'b0;
      cnt     <= 0;
    end else if (spark_i && !flame_o) begin
      cnt <= cnt + 1;
      if (cnt >= dly_i) flame_o <= 1'b1;
    end
  end
endmodule

//--- verif/pilot_ignition_retry_sequencer_tb_top.sv
`timescale 1ns/1ps
module pilot_ignition_retry_sequencer_tb_top;
  // shortened timebase so a full retry cycle fits in a short run
  localparam int TC = 4;
  localparam int TS = 15;
  localparam int TL = 30;
  localparam int PL = 10;
  localparam int WL = 40;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [3:0]  sel   = 4'hf;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        heat  = 1'b0;
  logic        damp  = 1'b0;
  logic        light = 1'b0;
  logic [3:0]  dly   = 4'h3;
  logic        flame, spark, pilot, mainv, dpwr, led, irq;
  wire  [5:0]  pins  = {irq, led, dpwr, mainv, pilot, spark};
  int          err_total = 0;
  int          n_checks  = 0;
  int          n, t0;
  int          cyc_n = 0;
  integer      seed  = 32'h8a84;
  logic [31:0] rnd;
  logic [31:0] exp_q[$];

  pilot_ignition_retry_sequencer #(
    .TICK_CYC(17'(TC)), .TRIAL_SHORT(19'(TS)), .TRIAL_LONG(19'(TL)),
    .PURGE_LEN(19'(PL)), .WAIT_LEN(19'(WL))
  ) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .heat_req_i(heat), .flame_i(flame), .damper_conn_i(damp), .spark_o(spark),
    .pilot_valve_o(pilot), .main_valve_o(mainv), .damper_pwr_o(dpwr), .led_o(led), .irq_o(irq)
  );

  appliance_model burner_u (
    .clk_i(clk_i), .spark_i(spark), .pilot_i(pilot), .light_en_i(light), .dly_i(dly), .flame_o(flame)
  );

  always #5 clk_i = ~clk_i;

  // free cycle count, used to time stages across bus traffic
  always @(posedge clk_i) cyc_n <= cyc_n + 1;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (e !== g) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rng(input string nm, input int v, input int lo, input int hi);
    n_checks++;
    if (v < lo || v > hi) begin
      err_total++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one classic cycle; the expected read word goes to the note queue
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  // waits for a pin level, sampled after the edge has settled
  task automatic wait_pin(input int k, input logic v, input int lim, output int c);
    c = 0;
    #1;
    while (pins[k] !== v && c < lim) begin
      @(posedge clk_i);
      #1;
      c++;
    end
  endtask

  // every ack delivers one result; written data must read back as zero
  always @(posedge clk_i) begin
    if (ack === 1'b1) begin
      if (exp_q.size() == 0) chk("wb_note", 32'h1, 32'h0);
      else chk("wb_dat", exp_q.pop_front(), rdat);
    end
  end

  initial begin
    #200000;
    err_total++;
    $display("MISMATCH watchdog expected done seen timeout");
    end_of_test();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 chk("pins_rst", 32'h0, 32'(pins));
    wb(1'b0, 8'h00, 32'h0, 32'h2);
    wb(1'b0, 8'h0c, 32'h0, 32'h0);
    wb(1'b0, 8'h04, 32'h0, 32'h0);
    wb(1'b1, 8'h10, 32'hffffffff, 32'h0);
    wb(1'b0, 8'h10, 32'h0, 32'h0);
    rnd = $random(seed);
    wb(1'b1, 8'h0c, rnd, 32'h0);
    wb(1'b0, 8'h0c, 32'h0, rnd & 32'hf);
    wb(1'b1, 8'h0c, 32'h0, 32'h0);
    wb(1'b0, 8'h08, 32'h0, 32'h0);
    // long trial with no flame, then the timed wait and a retry
    @(posedge clk_i) heat <= 1'b1;
    dly <= 4'($random(seed));
    wait_pin(0, 1'b1, 20, n);
    rng("trial_start", n, 1, 8);
    chk("pilot_trial", 32'h1, 32'(pilot));
    chk("main_trial", 32'h0, 32'(mainv));
    wait_pin(0, 1'b0, 400, n);
    t0 = cyc_n;
    // the stage timer counts ticks, so the free tick phase moves the end by up to one tick
    rng("long_trial", n, (TL-1)*TC+2, TL*TC+1);
    chk("fail_off", 32'h0, 32'(pins[2:0]));
    wb(1'b1, 8'h0c, 32'h1, 32'h0);
    wait_pin(5, 1'b1, 4, n);
    rng("irq_raise", n, 0, 3);
    wb(1'b0, 8'h04, 32'h0, 32'h114);
    wb(1'b0, 8'h08, 32'h0, 32'h1);
    wait_pin(5, 1'b0, 4, n);
    rng("irq_clear", n, 0, 3);
    chk("wait_off", 32'h0, 32'(pins[2:0]));
    wait_pin(0, 1'b1, 400, n);
    rng("retry_wait", cyc_n - t0, (WL-1)*TC+2, WL*TC+1);
    // pilot lights on the retry, then is blown out in run
    @(posedge clk_i) light <= 1'b1;
    wait_pin(2, 1'b1, 40, n);
    rng("main_open", n, 1, 30);
    chk("proven", 32'h1, 32'(flame));
    chk("spark_end", 32'h0, 32'(spark));
    repeat (8) @(posedge clk_i);
    #1 chk("led_run", 32'h1, 32'(led));
    @(posedge clk_i) light <= 1'b0;
    wait_pin(2, 1'b0, 10, n);
    rng("flame_loss", n, 1, 6);
    wait_pin(0, 1'b1, 4, n);
    rng("relight", n, 0, 2);
    @(posedge clk_i) light <= 1'b1;
    wait_pin(2, 1'b1, 40, n);
    @(posedge clk_i) heat <= 1'b0;
    wait_pin(2, 1'b0, 8, n);
    rng("heat_off", n, 1, 5);
    repeat (4) @(posedge clk_i);
    #1 chk("idle_off", 32'h0, 32'(pins[3:0]));
    wb(1'b0, 8'h04, 32'h0, 32'h0);
    wb(1'b0, 8'h08, 32'h0, 32'h6);
    // prepurge with the short trial
    @(posedge clk_i) light <= 1'b0;
    wb(1'b1, 8'h00, 32'h1, 32'h0);
    @(posedge clk_i) heat <= 1'b1;
    t0 = cyc_n;
    wait_pin(1, 1'b1, 200, n);
    rng("purge", cyc_n - t0, PL*TC, (PL+2)*TC+4);
    chk("spark_after_purge", 32'h1, 32'(spark));
    wait_pin(0, 1'b0, 200, n);
    rng("short_trial", n, (TS-1)*TC+2, TS*TC+1);
    @(posedge clk_i) heat <= 1'b0;
    // let the sequence reach idle and damper power drop before the next request
    repeat (6) @(posedge clk_i);
    // damper seen once, then missing
    @(posedge clk_i) begin
      damp <= 1'b1;
      heat <= 1'b1;
    end
    wait_pin(3, 1'b1, 8, n);
    rng("damper_pwr", n, 1, 4);
    wait_pin(1, 1'b1, 100, n);
    @(posedge clk_i) heat <= 1'b0;
    repeat (6) @(posedge clk_i);
    wb(1'b0, 8'h04, 32'h0, 32'h60);
    @(posedge clk_i) begin
      damp <= 1'b0;
      heat <= 1'b1;
    end
    wait_pin(1, 1'b1, 60, n);
    rng("damper_block", n, 60, 60);
    wb(1'b0, 8'h04, 32'h0, 32'h30);
    end_of_test();
  end
endmodule
